// *** rtl/pscfb_consts.vh ***
/*
  Constants for the performance-state control and feedback block: register
  numbers, field positions, reset values and timing counts.
  Assumes a 100 MHz core clock and a model-specific register port from the core.
*/
`ifndef PSCFB_CONSTS_VH
`define PSCFB_CONSTS_VH

`define PSCFB_REG_REF_CNT     16'h00E7
`define PSCFB_REG_ACT_CNT     16'h00E8
`define PSCFB_REG_STATUS      16'h0198
`define PSCFB_REG_TARGET      16'h0199
`define PSCFB_REG_MISC_EN     16'h01A0

`define PSCFB_MISC_EN_BIT     16
`define PSCFB_FEAT_ECX_BIT    7
`define PSCFB_PM_ECX_BIT      0

`define PSCFB_OP_RESET        16'h0000
`define PSCFB_OP_MAX          16'h0007

`define PSCFB_STEP_NS         100
`define PSCFB_CLK_NS          10
`define PSCFB_STEP_CYC        (`PSCFB_STEP_NS / `PSCFB_CLK_NS)
`define PSCFB_REF_DIV         4

`endif

// *** rtl/pscfb_ratediv.v ***
/*
  Rate enable divider: pulses its output one cycle in every div_i cycles,
  or every cycle when div_i is 1. Used to pace the actual counter.
  Assumes div_i holds steady for long stretches.
*/
`timescale 1ns/100ps
module pscfb_ratediv (
  input  wire       clk,      // Core clock
  input  wire       resetn,   // Async reset, active low
  input  wire       run_i,    // Count allowed
  input  wire [3:0] div_i,    // Division ratio, 1..15
  output reg        tick_o    // One-cycle enable
);
  reg [3:0] cnt_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r  <= 4'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      tick_o <= 1'b0;
    end else if (cnt_r + 4'h1 >= div_i) begin
      cnt_r  <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// *** rtl/pscfb_top.v ***
/*
  Performance-state control and feedback block for one logical processor:
  enable bit, operating-point target and status, fixed-rate and actual
  performance counters, and model-specific register access.
  Assumes the core issues one register access per strobe and that active,
  throttle and feature signals are synchronous to clk.
*/
`timescale 1ns/100ps
`include "pscfb_consts.vh"
module pscfb_top (
  input  wire        clk,          // Core clock, 100 MHz
  input  wire        resetn,       // Async reset, active low
  input  wire        msr_rd_i,     // Register read strobe
  input  wire        msr_wr_i,     // Register write strobe
  input  wire [15:0] msr_addr_i,   // Register number
  input  wire [63:0] msr_wdata_i,  // Write data
  input  wire        active_i,     // In active execution power state
  input  wire        throttle_i,   // Thermal or software throttling
  input  wire        ref_tick_i,   // Fixed boot-configured rate enable
  output reg  [63:0] msr_rdata_o,  // Read data
  output reg         msr_ack_o,    // Access done
  output reg         msr_err_o,    // Unmapped register
  output reg         feat_ecx_o,   // Mechanism support flag
  output reg         pm_ecx_o,     // Counter pair present flag
  output reg  [15:0] op_point_o,   // Operating point in effect
  output reg         busy_o        // Transition in progress
);
  // One-hot codes of the transition engine
  localparam ST_IDLE = 2'b01;
  localparam ST_MOVE = 2'b10;
  // Slots of the counter pair
  localparam CNT_REF = 0;
  localparam CNT_ACT = 1;

  // Register decode
  wire         acc_any;
  wire         sel_ref;
  wire         sel_act;
  wire         sel_status;
  wire         sel_target;
  wire         sel_misc;
  wire         wr_ref;
  wire         wr_act;
  wire         wr_target;
  wire         wr_misc;
  wire         hit;

  // Enable register
  reg  [63:0]  misc_en_r;
  reg  [63:0]  misc_en_nxt;
  wire         enabled;

  // Target register and transition engine
  reg  [1:0]   state_r;
  reg  [1:0]   state_nxt;
  reg  [15:0]  target_r;
  reg  [15:0]  target_nxt;
  reg          pend_r;
  reg          pend_nxt;
  reg  [15:0]  goal_r;
  reg  [15:0]  goal_nxt;
  reg  [15:0]  cur_r;
  reg  [15:0]  cur_nxt;
  reg  [7:0]   step_r;
  reg  [7:0]   step_nxt;
  wire         step_done;
  wire [15:0]  wr_op;

  // Counter pair
  wire         act_tick;
  wire         ref_inc;
  wire         act_inc;
  wire [1:0]   cnt_inc;
  wire [1:0]   cnt_wr;
  wire [1:0]   cnt_ovf;
  wire         wrap;
  wire [127:0] cnt_all;
  wire [63:0]  ref_cnt;
  wire [63:0]  act_cnt;
  wire [4:0]   act_div_w;
  wire [3:0]   act_div;

  // Register port next values
  reg  [63:0]  rd_nxt;
  reg  [63:0]  rdata_nxt;
  reg          ack_nxt;
  reg          err_nxt;

  assign acc_any    = msr_rd_i | msr_wr_i;
  assign sel_ref    = (msr_addr_i == `PSCFB_REG_REF_CNT);
  assign sel_act    = (msr_addr_i == `PSCFB_REG_ACT_CNT);
  assign sel_status = (msr_addr_i == `PSCFB_REG_STATUS);
  assign sel_target = (msr_addr_i == `PSCFB_REG_TARGET);
  assign sel_misc   = (msr_addr_i == `PSCFB_REG_MISC_EN);
  assign hit        = sel_ref | sel_act | sel_status | sel_target | sel_misc;
  // Status is read only: a write there is taken and dropped without error
  assign wr_ref     = msr_wr_i & sel_ref;
  assign wr_act     = msr_wr_i & sel_act;
  assign wr_target  = msr_wr_i & sel_target;
  assign wr_misc    = msr_wr_i & sel_misc;

  assign enabled = misc_en_r[`PSCFB_MISC_EN_BIT];
  // Codes above the top point are clamped to the highest one
  assign wr_op = (msr_wdata_i[15:0] > `PSCFB_OP_MAX) ? `PSCFB_OP_MAX : msr_wdata_i[15:0];
  // Lower point codes mean slower clock; throttling halves the rate again
  assign act_div_w = {1'b0, 4'h8 - cur_r[3:0]} << throttle_i;
  // A halved rate at the lowest point does not fit the divider: slowest ratio used
  assign act_div = act_div_w[4] ? 4'hF : act_div_w[3:0];

  pscfb_ratediv u_div (
    .clk    (clk),
    .resetn (resetn),
    .run_i  (active_i),
    .div_i  (act_div),
    .tick_o (act_tick)
  );

  // Upper bits of target and status, and unmapped numbers, read as zero; the enable register reads back all 64 written bits
  always @* begin
    rd_nxt = 64'h0;
    case (msr_addr_i)
      `PSCFB_REG_REF_CNT: begin
        rd_nxt = ref_cnt;
      end
      `PSCFB_REG_ACT_CNT: begin
        rd_nxt = act_cnt;
      end
      `PSCFB_REG_TARGET: begin
        rd_nxt = {48'h0, target_r};
      end
      `PSCFB_REG_STATUS: begin
        rd_nxt = {48'h0, cur_r};
      end
      `PSCFB_REG_MISC_EN: begin
        rd_nxt = misc_en_r;
      end
      default: begin
        rd_nxt = 64'h0;
      end
    endcase
  end

  always @* begin
    ack_nxt   = acc_any;
    err_nxt   = acc_any & ~hit;
    rdata_nxt = msr_rdata_o;
    // Read data holds until the next read
    if (msr_rd_i) begin
      rdata_nxt = rd_nxt;
    end
  end

  always @* begin
    misc_en_nxt = misc_en_r;
    if (wr_misc) begin
      misc_en_nxt = msr_wdata_i;
    end
  end

  // Support flags rise on the first edge after reset and then stay up
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feat_ecx_o <= 1'b0;
      pm_ecx_o   <= 1'b0;
    end else begin
      feat_ecx_o <= 1'b1;
      pm_ecx_o   <= 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msr_ack_o <= 1'b0;
      msr_err_o <= 1'b0;
    end else begin
      msr_ack_o <= ack_nxt;
      msr_err_o <= err_nxt;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msr_rdata_o <= 64'h0;
    end else begin
      msr_rdata_o <= rdata_nxt;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      misc_en_r <= 64'h0;
    end else begin
      misc_en_r <= misc_en_nxt;
    end
  end

  assign step_done = (step_r == `PSCFB_STEP_CYC - 1);

  // Target register and transition engine
  always @* begin
    state_nxt  = state_r;
    target_nxt = target_r;
    pend_nxt   = pend_r;
    goal_nxt   = goal_r;
    cur_nxt    = cur_r;
    step_nxt   = step_r;
    if (wr_target) begin
      target_nxt = wr_op;
      pend_nxt   = 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        // A write in this same cycle stays pending for the next run
        if (pend_r && enabled) begin
          pend_nxt  = wr_target;
          goal_nxt  = target_r;
          step_nxt  = 8'h00;
          state_nxt = ST_MOVE;
        end
      end
      ST_MOVE: begin
        // One code step per interval, so the status walks through each point
        if (step_done) begin
          step_nxt = 8'h00;
          if (cur_r < goal_r) begin
            cur_nxt = cur_r + 16'h0001;
          end else if (cur_r > goal_r) begin
            cur_nxt = cur_r - 16'h0001;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else begin
          step_nxt = step_r + 8'h01;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= ST_IDLE;
      target_r <= `PSCFB_OP_RESET;
      pend_r   <= 1'b0;
      goal_r   <= `PSCFB_OP_RESET;
      cur_r    <= `PSCFB_OP_RESET;
      step_r   <= 8'h00;
    end else begin
      state_r  <= state_nxt;
      target_r <= target_nxt;
      pend_r   <= pend_nxt;
      goal_r   <= goal_nxt;
      cur_r    <= cur_nxt;
      step_r   <= step_nxt;
    end
  end

  // Output copies lag the engine by one cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_point_o <= `PSCFB_OP_RESET;
      busy_o     <= 1'b0;
    end else begin
      op_point_o <= cur_r;
      busy_o     <= (state_r == ST_MOVE);
    end
  end

  assign ref_inc          = active_i & ref_tick_i;
  assign act_inc          = active_i & act_tick;
  assign cnt_inc[CNT_REF] = ref_inc;
  assign cnt_inc[CNT_ACT] = act_inc;
  assign cnt_wr[CNT_REF]  = wr_ref;
  assign cnt_wr[CNT_ACT]  = wr_act;
  // Overflow of either counter clears both in the same cycle
  assign wrap             = |cnt_ovf;

  // A software write wins over counting and wrap for that counter only
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cnt
      reg  [63:0] val_r;
      reg  [63:0] val_nxt;
      assign cnt_ovf[g] = cnt_inc[g] & (&val_r);
      assign cnt_all[64*g +: 64] = val_r;
      always @* begin
        val_nxt = val_r;
        if (cnt_wr[g]) begin
          val_nxt = msr_wdata_i;
        end else if (wrap) begin
          val_nxt = 64'h0;
        end else if (cnt_inc[g]) begin
          val_nxt = val_r + 64'h1;
        end
      end
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          val_r <= 64'h0;
        end else begin
          val_r <= val_nxt;
        end
      end
    end
  endgenerate

  assign ref_cnt = cnt_all[63:0];
  assign act_cnt = cnt_all[127:64];
endmodule

// *** verification/pscfb_monitor.sv ***
/* Checker for pscfb_top: register handshake, flags, operating-point steps.
   Assumes one clock domain and bind to every pscfb_top instance. */
`timescale 1ns/100ps
module pscfb_monitor (
  input logic        clk,         // Core clock
  input logic        resetn,      // Async reset, active low
  input logic        msr_rd_i,    // Read strobe
  input logic        msr_wr_i,    // Write strobe
  input logic [63:0] msr_rdata_o, // Read data
  input logic        msr_ack_o,   // Access done
  input logic        msr_err_o,   // Unmapped register
  input logic        feat_ecx_o,  // Support flag
  input logic        pm_ecx_o,    // Counter pair flag
  input logic [15:0] op_point_o,  // Point in effect
  input logic        busy_o       // Transition running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_step;
    $changed(op_point_o);
  endsequence
  a_ack_follows: assert property ((msr_rd_i || msr_wr_i) |=> msr_ack_o)
    else $error("ack missing");
  a_ack_only: assert property (!(msr_rd_i || msr_wr_i) |=> !msr_ack_o)
    else $error("stray ack");
  a_err_with_ack: assert property (msr_err_o |-> msr_ack_o)
    else $error("err without ack");
  a_flags_set: assert property ($past(resetn) |-> feat_ecx_o && pm_ecx_o)
    else $error("flag low");
  a_rdata_hold: assert property (!msr_rd_i |=> $stable(msr_rdata_o))
    else $error("read data moved");
  a_step_size: assert property (s_step |-> (op_point_o - $past(op_point_o) == 16'h0001)
    || (op_point_o - $past(op_point_o) == 16'hFFFF)) else $error("step not one");
  a_step_spacing: assert property (s_step |=> $stable(op_point_o)[*8])
    else $error("steps too close");
  a_idle_still: assert property (!busy_o |=> $stable(op_point_o))
    else $error("point moved while idle");
endmodule
bind pscfb_top pscfb_monitor i_pscfb_monitor (.clk(clk), .resetn(resetn), .msr_rd_i(msr_rd_i),
  .msr_wr_i(msr_wr_i), .msr_rdata_o(msr_rdata_o), .msr_ack_o(msr_ack_o), .msr_err_o(msr_err_o),
  .feat_ecx_o(feat_ecx_o), .pm_ecx_o(pm_ecx_o), .op_point_o(op_point_o), .busy_o(busy_o));

// *** verification/pscfb_top_tb.sv ***
/* Self-checking bench for pscfb_top: registers, transitions, counters.
   Assumes the monitor is bound to the design by its own file. */
`timescale 1ns/100ps
module pscfb_top_tb;
  typedef struct {logic [15:0] a; logic [63:0] d; logic [63:0] x; logic e;} pscfb_row_t;
  logic        clk, resetn, msr_rd_i, msr_wr_i, active_i, throttle_i, ref_tick_i;
  logic        msr_ack_o, msr_err_o, feat_ecx_o, pm_ecx_o, busy_o;
  logic [15:0] msr_addr_i, op_point_o;
  logic [63:0] msr_wdata_i, msr_rdata_o, rd_v;
  integer      error_cnt, comparisons, n, k;
  pscfb_row_t  rows [6] = '{'{16'h00E7, 64'h0123_4567_89AB_CDEF, 64'h0123_4567_89AB_CDEF, 1'b0},
    '{16'h00E8, 64'hFEDC_BA98_7654_3210, 64'hFEDC_BA98_7654_3210, 1'b0},
    '{16'h0198, 64'h5, 64'h0, 1'b0}, '{16'h0199, 64'hABCD, 64'h7, 1'b0},
    '{16'h0199, 64'h0, 64'h0, 1'b0}, '{16'h0123, 64'h5, 64'h0, 1'b1}};
  pscfb_top i_pscfb_top (.clk(clk), .resetn(resetn), .msr_rd_i(msr_rd_i), .msr_wr_i(msr_wr_i),
    .msr_addr_i(msr_addr_i), .msr_wdata_i(msr_wdata_i), .active_i(active_i),
    .throttle_i(throttle_i), .ref_tick_i(ref_tick_i), .msr_rdata_o(msr_rdata_o),
    .msr_ack_o(msr_ack_o), .msr_err_o(msr_err_o), .feat_ecx_o(feat_ecx_o),
    .pm_ecx_o(pm_ecx_o), .op_point_o(op_point_o), .busy_o(busy_o));
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [63:0] d, input logic e);
    @(posedge clk);
    msr_wr_i <= w;
    msr_rd_i <= !w;
    msr_addr_i <= a;
    msr_wdata_i <= d;
    @(posedge clk);
    msr_wr_i <= 1'b0;
    msr_rd_i <= 1'b0;
    #1;
    chk(msr_ack_o, 64'h1);
    chk(msr_err_o, e);
    rd_v = msr_rdata_o;
  endtask
  task wt(input logic [15:0] v);
    n = 0;
    while (op_point_o !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(op_point_o, v);
  endtask
  task end_of_test;
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    error_cnt = 0;
    comparisons = 0;
    {msr_rd_i, msr_wr_i, active_i, throttle_i, ref_tick_i} = 5'h00;
    msr_addr_i = 16'h0000;
    msr_wdata_i = 64'h0;
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    chk({feat_ecx_o, pm_ecx_o, busy_o, op_point_o}, 64'h0);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({feat_ecx_o, pm_ecx_o}, 64'h3);
    acc(0, 16'h01A0, 64'h0, 0);
    chk(rd_v, 64'h0);
    foreach (rows[i]) begin
      acc(1, rows[i].a, rows[i].d, rows[i].e);
      acc(0, rows[i].a, 64'h0, rows[i].e);
      chk(rd_v, rows[i].x);
    end
    repeat (30) @(posedge clk);
    #1;
    chk(op_point_o, 64'h0);
    acc(1, 16'h01A0, 64'h0000_0000_0001_0000, 0);
    repeat (30) @(posedge clk);
    acc(1, 16'h0199, 64'h3, 0);
    wt(16'h0001);
    acc(1, 16'h0199, 64'h1, 0);
    wt(16'h0003);
    acc(0, 16'h0199, 64'h0, 0);
    chk(rd_v, 64'h1);
    wt(16'h0001);
    acc(0, 16'h0198, 64'h0, 0);
    chk(rd_v, 64'h1);
    for (k = 0; k < 2; k++) begin
      acc(1, 16'h00E7, 64'h0, 0);
      acc(1, 16'h00E8, 64'h0, 0);
      @(posedge clk);
      {active_i, ref_tick_i, throttle_i} <= {2'h3, k[0]};
      repeat (42) @(posedge clk);
      {active_i, ref_tick_i} <= 2'h0;
      acc(0, 16'h00E7, 64'h0, 0);
      chk(rd_v, 64'h2A);
      acc(0, 16'h00E8, 64'h0, 0);
      chk(rd_v + 1 >= (6 >> k) && rd_v <= (6 >> k), 64'h1);
    end
    acc(1, 16'h00E7, 64'hFFFF_FFFF_FFFF_FFFE, 0);
    acc(1, 16'h00E8, 64'h5, 0);
    @(posedge clk);
    {active_i, ref_tick_i} <= 2'h3;
    repeat (2) @(posedge clk);
    {active_i, ref_tick_i} <= 2'h0;
    acc(0, 16'h00E8, 64'h0, 0);
    chk(rd_v, 64'h0);
    acc(0, 16'h00E7, 64'h0, 0);
    chk(rd_v, 64'h0);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    acc(0, 16'h01A0, 64'h0, 0);
    chk(rd_v, 64'h0);
    end_of_test;
  end
endmodule
